/* logic/crfc_pkg.sv */
// Shared constants for the clock ratio frequency counter
package crfc_pkg;

  // Register addresses
  localparam logic [15:0] CTRL_ADDR = 16'h009B;
  localparam logic [15:0] INTERVAL_ADDR = 16'h009D;
  localparam logic [15:0] COUNT_ADDR = 16'h4008;

  // Control register fields
  localparam int DONE_BIT = 7;
  localparam int BUSY_BIT = 6;
  localparam int SEL_BIT = 5;
  localparam int MODE_MSB = 2;
  localparam int MODE_LSB = 0;

  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] INTERVAL_RST = 8'h00;

  // Widths
  localparam int MODE_W = 3;
  localparam int IVL_W = 6;
  localparam int CNT_W = 23;
  localparam int IVL_CNT_W = 24;

  // Interval field limit above which one cycle is used
  localparam logic [5:0] IVL_MAX = 6'h2B;
  localparam logic [23:0] IVL_BASE_EVEN = 24'h000002;
  localparam logic [23:0] IVL_BASE_ODD = 24'h000003;
  localparam logic [23:0] IVL_FORCED = 24'h000001;

  // Interval clock source codes
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_REF = 3'h1;
  localparam logic [2:0] MODE_OSC = 3'h2;
  localparam logic [2:0] MODE_SYS = 3'h3;
  localparam logic [2:0] MODE_XO = 3'h4;
  localparam logic [2:0] MODE_SLEEP = 3'h6;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN} crfc_state_t;

endpackage

/* logic/crfc_edge_if.sv */
// Carrier between a raw clock sample and its synchronised rising edge
`timescale 1ns/1ps
`default_nettype none
interface crfc_edge_if;
  logic raw;
  logic rise;
  modport src (output raw, input rise);
  modport sink (input raw, output rise);
endinterface
`default_nettype wire

/* logic/crfc_edge_sync.sv */
// Two-flop synchroniser with rising edge detector
`timescale 1ns/1ps
`default_nettype none
module crfc_edge_sync (
  input wire logic clk,
  input wire logic rst,
  crfc_edge_if.sink edge_io
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  // Only the second stage reads the first
  // History held high in reset: a pin already high gives no edge
  always_ff @(posedge clk) begin
    meta_ff <= edge_io.raw;
    sync_ff <= meta_ff;
    last_ff <= rst ? 1'b1 : sync_ff;
  end

  assign edge_io.rise = sync_ff & ~last_ff;
endmodule
`default_nettype wire

/* logic/crfc_top.sv */
// Clock ratio frequency counter with its register slave
`timescale 1ns/1ps
`default_nettype none
module crfc_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic ref_clk_gpio,
  input wire logic osc_clk,
  input wire logic sys_div_clk,
  input wire logic crystal_clock,
  input wire logic sleep_timer_clk,
  input wire logic lc_oscillator_clock,
  input wire logic divider_clock,
  output logic measure_complete_flag,
  output logic lc_count_enable,
  output logic div_count_enable
);

  // Register state
  logic [2:0] interval_source_mode_ff;
  logic counted_clock_select_ff;
  logic measure_complete_flag_ff;
  logic [5:0] measure_interval_setting_ff;
  logic [22:0] main_event_counter_ff;
  logic [23:0] ivl_cnt_ff;
  logic [7:0] rdata_ff;
  logic lc_en_ff;
  logic div_en_ff;
  crfc_pkg::crfc_state_t state_ff;

  // Next values
  crfc_pkg::crfc_state_t nxt_state;
  logic [2:0] nxt_mode;
  logic nxt_sel;
  logic nxt_done;
  logic [5:0] nxt_interval;
  logic [22:0] nxt_count;
  logic [23:0] nxt_ivl_cnt;
  logic [7:0] nxt_rdata;

  // Register decode
  wire ctrl_sel = (sfr_addr == crfc_pkg::CTRL_ADDR);
  wire ivl_sel = (sfr_addr == crfc_pkg::INTERVAL_ADDR);
  wire ctrl_wr = sfr_wr && ctrl_sel;
  wire ivl_wr = sfr_wr && ivl_sel;
  wire [2:0] wr_mode = sfr_wdata[crfc_pkg::MODE_MSB:crfc_pkg::MODE_LSB];
  wire trigger = ctrl_wr && sfr_wdata[crfc_pkg::BUSY_BIT];
  wire trig_ok = trigger && (wr_mode != crfc_pkg::MODE_OFF);
  wire mode_off = (interval_source_mode_ff == crfc_pkg::MODE_OFF);
  wire mode_kill = ctrl_wr ? (wr_mode == crfc_pkg::MODE_OFF) : mode_off;
  wire busy = (state_ff != crfc_pkg::ST_IDLE);

  // Every pin crosses two flops before any selector sees it
  wire [6:0] pin_raw = {divider_clock, lc_oscillator_clock,
    sleep_timer_clk, crystal_clock, sys_div_clk, osc_clk, ref_clk_gpio};
  wire [6:0] pin_rise;

  for (genvar gi = 0; gi < 7; gi++) begin : g_pin_sync
    crfc_edge_if pin_edge ();
    assign pin_edge.raw = pin_raw[gi];
    assign pin_rise[gi] = pin_edge.rise;
    crfc_edge_sync u_sync (
      .clk(clk),
      .rst(rst),
      .edge_io(pin_edge.sink)
    );
  end

  // Interval clock selector
  wire ivl_rise =
    (interval_source_mode_ff == crfc_pkg::MODE_REF) ? pin_rise[0] :
    (interval_source_mode_ff == crfc_pkg::MODE_OSC) ? pin_rise[1] :
    (interval_source_mode_ff == crfc_pkg::MODE_SYS) ? pin_rise[2] :
    (interval_source_mode_ff == crfc_pkg::MODE_XO) ? pin_rise[3] :
    (interval_source_mode_ff == crfc_pkg::MODE_SLEEP) ? pin_rise[4] :
    1'b0;

  // Counted clock selector, quiet while disabled
  wire cnt_rise = mode_off ? 1'b0 :
    (counted_clock_select_ff ? pin_rise[6] : pin_rise[5]);

  // Interval length
  wire [23:0] ivl_base = measure_interval_setting_ff[0] ?
    crfc_pkg::IVL_BASE_ODD : crfc_pkg::IVL_BASE_EVEN;
  wire [23:0] ivl_shift = ivl_base << measure_interval_setting_ff[5:1];
  wire ivl_over = (measure_interval_setting_ff > crfc_pkg::IVL_MAX);
  wire [23:0] ivl_target = ivl_over ? crfc_pkg::IVL_FORCED : ivl_shift;
  wire [23:0] ivl_cnt_inc = ivl_cnt_ff + 24'h000001;
  wire ivl_last = (ivl_cnt_inc == ivl_target);
  wire in_run = (state_ff == crfc_pkg::ST_RUN);
  wire finish = in_run && ivl_rise && ivl_last;
  wire done_set = finish && !trig_ok && !mode_kill;

  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      crfc_pkg::ST_IDLE: nxt_state = state_ff;
      crfc_pkg::ST_WAIT: if (ivl_rise) nxt_state = crfc_pkg::ST_RUN;
      crfc_pkg::ST_RUN: if (finish) nxt_state = crfc_pkg::ST_IDLE;
    endcase
    if (mode_kill) begin
      nxt_state = crfc_pkg::ST_IDLE;
    end
    if (trig_ok) begin
      nxt_state = crfc_pkg::ST_WAIT;
    end
  end

  // Interval edge counter
  assign nxt_ivl_cnt = !in_run ? 24'h000000 :
    (ivl_rise ? ivl_cnt_inc : ivl_cnt_ff);

  // Main counter, cleared on restart or disable
  assign nxt_count = (trig_ok || mode_kill) ? 23'h000000 :
    ((in_run && cnt_rise) ? main_event_counter_ff + 23'h000001 :
    main_event_counter_ff);

  // Control fields; bits 4:3 are not stored
  assign nxt_mode = ctrl_wr ? wr_mode : interval_source_mode_ff;
  assign nxt_sel = ctrl_wr ? sfr_wdata[crfc_pkg::SEL_BIT] :
    counted_clock_select_ff;
  assign nxt_interval = ivl_wr ? sfr_wdata[5:0] : measure_interval_setting_ff;

  // Done flag: hardware set wins over a software clear, unless that write disables or restarts
  assign nxt_done = done_set ? 1'b1 :
    (ctrl_wr ? (sfr_wdata[crfc_pkg::DONE_BIT] & ~trigger) :
    measure_complete_flag_ff);

  // Read data
  wire [31:0] count_word = {9'h000, main_event_counter_ff};
  wire [7:0] ctrl_rd = {measure_complete_flag_ff, busy,
    counted_clock_select_ff, 2'h0, interval_source_mode_ff};
  wire [7:0] ivl_rd = {2'h0, measure_interval_setting_ff};
  wire [15:0] cnt_off = sfr_addr - crfc_pkg::COUNT_ADDR;
  wire cnt_hit = (cnt_off[15:2] == 14'h0000);
  wire [7:0] cnt_rd = (cnt_off[1:0] == 2'h0) ? count_word[31:24] :
    (cnt_off[1:0] == 2'h1) ? count_word[23:16] :
    (cnt_off[1:0] == 2'h2) ? count_word[15:8] :
    count_word[7:0];
  assign nxt_rdata = !sfr_rd ? 8'h00 :
    ctrl_sel ? ctrl_rd :
    ivl_sel ? ivl_rd :
    cnt_hit ? cnt_rd : 8'h00;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= crfc_pkg::ST_IDLE;
      ivl_cnt_ff <= 24'h000000;
      main_event_counter_ff <= 23'h000000;
    end else begin
      state_ff <= nxt_state;
      ivl_cnt_ff <= nxt_ivl_cnt;
      main_event_counter_ff <= nxt_count;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      interval_source_mode_ff <= crfc_pkg::CTRL_RST[2:0];
      counted_clock_select_ff <= crfc_pkg::CTRL_RST[5];
      measure_complete_flag_ff <= crfc_pkg::CTRL_RST[7];
      measure_interval_setting_ff <= crfc_pkg::INTERVAL_RST[5:0];
    end else begin
      interval_source_mode_ff <= nxt_mode;
      counted_clock_select_ff <= nxt_sel;
      measure_complete_flag_ff <= nxt_done;
      measure_interval_setting_ff <= nxt_interval;
    end
  end

  // Output flops
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= 8'h00;
      lc_en_ff <= 1'b0;
      div_en_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      lc_en_ff <= (nxt_mode != crfc_pkg::MODE_OFF) && !nxt_sel;
      div_en_ff <= (nxt_mode != crfc_pkg::MODE_OFF) && nxt_sel;
    end
  end

  assign sfr_rdata = rdata_ff;
  assign measure_complete_flag = measure_complete_flag_ff;
  assign lc_count_enable = lc_en_ff;
  assign div_count_enable = div_en_ff;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_done_holds:
  assert property (measure_complete_flag_ff && !ctrl_wr |=>
    measure_complete_flag_ff)
  else $error("done flag dropped without a write");

  a_trig_clears:
  assert property (trigger && !done_set |=> !measure_complete_flag_ff)
  else $error("busy write did not clear done");

  a_done_write:
  assert property (ctrl_wr && sfr_wdata[7] && !sfr_wdata[6] |=>
    measure_complete_flag_ff)
  else $error("writing one to done did not set it");

  a_finish_done:
  assert property (done_set |=> measure_complete_flag_ff && !busy)
  else $error("completion did not set done and drop busy");

  a_restart_clr:
  assert property (trig_ok |=> busy && main_event_counter_ff == 23'h000000
    && state_ff == crfc_pkg::ST_WAIT)
  else $error("restart did not rearm the counter");

  a_busy_read:
  assert property (sfr_rd && ctrl_sel |=> rdata_ff[6] == $past(busy))
  else $error("busy bit read mismatch");

  a_sel_route:
  assert property (lc_en_ff == (!mode_off && !counted_clock_select_ff) &&
    div_en_ff == (!mode_off && counted_clock_select_ff))
  else $error("counted clock enables do not follow select");

  a_off_quiet:
  assert property (mode_off |-> !lc_en_ff && !div_en_ff &&
    !cnt_rise)
  else $error("counted clocks active while disabled");

  a_resv_zero:
  assert property (sfr_rd && ctrl_sel |=> rdata_ff[4:3] == 2'h0)
  else $error("reserved control bits not zero");

  a_interval_len:
  assert property (in_run |-> ivl_cnt_ff < ivl_target)
  else $error("interval counter passed its length");

  a_cap_one:
  assert property (in_run && ivl_over && ivl_rise && !trig_ok && !mode_kill
    |=> state_ff == crfc_pkg::ST_IDLE)
  else $error("oversized interval did not end after one cycle");

  a_upper_zero:
  assert property (sfr_rd && sfr_addr == crfc_pkg::COUNT_ADDR |=>
    rdata_ff == 8'h00)
  else $error("count top byte not zero");

  a_live_read:
  assert property (sfr_rd && cnt_hit && cnt_off[1:0] == 2'h3 |=>
    rdata_ff == $past(main_event_counter_ff[7:0]))
  else $error("count read not live");

  a_wait_start:
  assert property (state_ff == crfc_pkg::ST_WAIT && ivl_rise && !trig_ok
    && !mode_kill |=> in_run && ivl_cnt_ff == 24'h000000)
  else $error("run did not start on interval edge");

  a_count_hold:
  assert property (state_ff == crfc_pkg::ST_IDLE && !trig_ok && !mode_kill
    |=> $stable(main_event_counter_ff))
  else $error("idle count changed");

  a_mode_idle:
  assert property (mode_off |-> state_ff == crfc_pkg::ST_IDLE &&
    main_event_counter_ff == 23'h000000)
  else $error("counter active while disabled");

  a_resv_quiet:
  assert property ((interval_source_mode_ff == 3'h5 ||
    interval_source_mode_ff == 3'h7) |-> !ivl_rise)
  else $error("reserved mode passed an interval edge");

  a_sleep_route:
  assert property (interval_source_mode_ff == crfc_pkg::MODE_SLEEP |->
    ivl_rise == pin_rise[4])
  else $error("sleep mode not routed to its pin");

  a_cnt_route:
  assert property (!mode_off && counted_clock_select_ff |->
    cnt_rise == pin_rise[6])
  else $error("divider clock not routed to the counter");

  a_mid_byte:
  assert property (sfr_rd && sfr_addr == crfc_pkg::COUNT_ADDR + 16'h0001
    |=> rdata_ff == {1'b0, $past(main_event_counter_ff[22:16])})
  else $error("count byte one wrong");

  a_byte_two:
  assert property (sfr_rd && sfr_addr == crfc_pkg::COUNT_ADDR + 16'h0002
    |=> rdata_ff == $past(main_event_counter_ff[15:8]))
  else $error("count byte two wrong");

  a_done_source:
  assert property (!measure_complete_flag_ff && !ctrl_wr && !done_set |=>
    !measure_complete_flag_ff)
  else $error("done set without completion or write");

  a_run_ends:
  assert property (in_run && !ctrl_wr |=> busy || measure_complete_flag_ff)
  else $error("run ended without setting done");

  a_wait_hold:
  assert property (state_ff == crfc_pkg::ST_WAIT && !ivl_rise && !ctrl_wr
    |=> state_ff == crfc_pkg::ST_WAIT)
  else $error("run started without an interval edge");

  a_ivl_resv:
  assert property (sfr_rd && ivl_sel |=> rdata_ff[7:6] == 2'h0)
  else $error("interval reserved bits not zero");

  c_full_run: cover property (trig_ok ##[1:200] done_set);

  c_restart: cover property (in_run && trig_ok);

  c_disable_run: cover property (in_run && mode_kill);

  c_sw_done: cover property (ctrl_wr && sfr_wdata[7] && !busy);

  c_capped: cover property (in_run && ivl_over && ivl_rise);

endmodule
`default_nettype wire

/* verification/test_crfc_top.sv */
// Self-checking testbench for the clock ratio frequency counter
`timescale 1ns/1ps
`default_nettype none
module test_crfc_top;
  logic clk, rst, sfr_wr, sfr_rd;
  logic [15:0] sfr_addr;
  logic [7:0] sfr_wdata, sfr_rdata;
  logic ref_clk_gpio, osc_clk, sys_div_clk, crystal_clock, sleep_timer_clk;
  logic lc_oscillator_clock, divider_clock;
  logic measure_complete_flag, lc_count_enable, div_count_enable;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;

  crfc_top dut (
    .clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .ref_clk_gpio(ref_clk_gpio), .osc_clk(osc_clk),
    .sys_div_clk(sys_div_clk), .crystal_clock(crystal_clock),
    .sleep_timer_clk(sleep_timer_clk),
    .lc_oscillator_clock(lc_oscillator_clock),
    .divider_clock(divider_clock),
    .measure_complete_flag(measure_complete_flag),
    .lc_count_enable(lc_count_enable), .div_count_enable(div_count_enable)
  );

  initial begin
    clk = 1'b0; rst = 1'b1; sfr_wr = 1'b0; sfr_rd = 1'b0;
    sfr_addr = 16'h0000; sfr_wdata = 8'h00;
    ref_clk_gpio = 1'b0; osc_clk = 1'b0; sys_div_clk = 1'b0;
    crystal_clock = 1'b0; sleep_timer_clk = 1'b0;
    lc_oscillator_clock = 1'b0; divider_clock = 1'b0;
  end

  always #2.5 clk = ~clk;

  // Source clocks as fixed multiples of the system clock
  always @(posedge clk) begin
    #1;
    cyc++;
    ref_clk_gpio = (cyc % 16) < 8;
    osc_clk = (cyc % 20) < 10;
    sys_div_clk = (cyc % 24) < 12;
    crystal_clock = (cyc % 28) < 14;
    sleep_timer_clk = (cyc % 32) < 16;
    lc_oscillator_clock = (cyc % 4) < 2;
    divider_clock = (cyc % 8) < 4;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    idle(1);
    sfr_wr = 1'b0;
    idle(1);
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    sfr_addr = a;
    sfr_rd = 1'b1;
    idle(1);
    sfr_rd = 1'b0;
    d = sfr_rdata;
    idle(1);
  endtask

  task automatic rd_count(output logic [31:0] v);
    logic [7:0] b;
    for (int i = 0; i < 4; i++) begin
      rd(crfc_pkg::COUNT_ADDR + 16'(i), b);
      v = {v[23:0], b};
    end
  endtask

  task automatic wait_done;
    int i;
    for (i = 0; i < 20000 && measure_complete_flag !== 1'b1; i++) begin
      idle(1);
    end
    if (i == 20000) begin
      miscompares++;
      $display("[ERR] done_wait expected 1 seen timeout");
      close_out();
    end
  endtask

  task automatic regs_case;
    logic [7:0] d;
    logic [31:0] v;
    rd(crfc_pkg::CTRL_ADDR, d);
    check("ctrl_reset", d, 8'h00);
    rd(crfc_pkg::INTERVAL_ADDR, d);
    check("interval_reset", d, 8'h00);
    rd(16'h009C, d);
    check("unmapped_read", d, 8'h00);
    wr(crfc_pkg::INTERVAL_ADDR, 8'hFF);
    rd(crfc_pkg::INTERVAL_ADDR, d);
    check("interval_rw", d, 8'h3F);
    wr(crfc_pkg::COUNT_ADDR + 16'h0003, 8'hFF);
    rd_count(v);
    check("count_ro", v, 32'h00000000);
  endtask

  task automatic ctrl_case;
    logic [7:0] d;
    wr(crfc_pkg::CTRL_ADDR, 8'hFF);
    rd(crfc_pkg::CTRL_ADDR, d);
    check("ctrl_reserved", d, 8'h67);
    check("div_en_on", div_count_enable, 1'b1);
    check("lc_en_off", lc_count_enable, 1'b0);
    wr(crfc_pkg::CTRL_ADDR, 8'h20);
    rd(crfc_pkg::CTRL_ADDR, d);
    check("ctrl_disabled", d, 8'h20);
    check("div_en_mode0", div_count_enable, 1'b0);
    check("lc_en_mode0", lc_count_enable, 1'b0);
  endtask

  task automatic done_case;
    logic [7:0] d;
    wr(crfc_pkg::CTRL_ADDR, 8'h80);
    rd(crfc_pkg::CTRL_ADDR, d);
    check("done_sw_set", d, 8'h80);
    idle(5);
    check("done_level", measure_complete_flag, 1'b1);
    wr(crfc_pkg::CTRL_ADDR, 8'h00);
    idle(1);
    check("done_sw_clear", measure_complete_flag, 1'b0);
    wr(crfc_pkg::CTRL_ADDR, 8'h80);
  endtask

  task automatic measure(input logic [2:0] mode, input logic sel,
                         input logic [5:0] ivl, input int per);
    logic [7:0] d;
    logic [31:0] v, w;
    int n, e;
    n = (ivl > 6'h2B) ? 1 : (2 + ivl[0]) << ivl[5:1];
    e = n * per / (sel ? 8 : 4);
    wr(crfc_pkg::INTERVAL_ADDR, {2'h0, ivl});
    wr(crfc_pkg::CTRL_ADDR, {2'h1, sel, 2'h0, mode});
    rd(crfc_pkg::CTRL_ADDR, d);
    check("ctrl_busy", d, {2'h1, sel, 2'h0, mode});
    check("lc_en", lc_count_enable, !sel);
    check("div_en", div_count_enable, sel);
    wait_done();
    rd(crfc_pkg::CTRL_ADDR, d);
    check("ctrl_done", d, {2'h2, sel, 2'h0, mode});
    rd_count(v);
    check("count_top", v[31:23], 9'h000);
    check("count_range", 32'(v + 1 >= e && v <= e + 1), 1);
    idle(40);
    rd_count(w);
    check("count_hold", w, v);
    check("done_holds", measure_complete_flag, 1'b1);
  endtask

  task automatic restart_case;
    logic [7:0] d;
    logic [31:0] a, b;
    wr(crfc_pkg::INTERVAL_ADDR, 8'h09);
    wr(crfc_pkg::CTRL_ADDR, 8'h41);
    idle(300);
    rd_count(a);
    idle(40);
    rd_count(b);
    check("count_live", 32'(a != b && a != 0), 1);
    wr(crfc_pkg::CTRL_ADDR, 8'h41);
    rd(crfc_pkg::CTRL_ADDR, d);
    check("restart_busy", d, 8'h41);
    rd_count(a);
    check("restart_cleared", 32'(a < b), 1);
    idle(100);
    wr(crfc_pkg::CTRL_ADDR, 8'h00);
    rd(crfc_pkg::CTRL_ADDR, d);
    check("stop_ctrl", d, 8'h00);
    check("stop_done", measure_complete_flag, 1'b0);
    rd_count(a);
    check("stop_count", a, 32'h00000000);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    regs_case();
    ctrl_case();
    done_case();
    measure(crfc_pkg::MODE_REF, 1'b0, 6'h00, 16);
    measure(crfc_pkg::MODE_OSC, 1'b1, 6'h03, 20);
    measure(crfc_pkg::MODE_SYS, 1'b0, 6'h2C, 24);
    measure(crfc_pkg::MODE_XO, 1'b0, 6'h01, 28);
    measure(crfc_pkg::MODE_SLEEP, 1'b1, 6'h02, 32);
    restart_case();
    close_out();
  end
endmodule
`default_nettype wire
